// ===== verilog/msc_pkg.sv
// Constants, types and command codes for the meter status and system command block.
// How it works
// - Self-test query runs test, queues result code.
// - Result zero means pass, nonzero means failure.
// - Wait command accepted, changes nothing.
// - Beeper enable settable, readable; immediate beep once.
// - Version query returns level 1999.0.
// - Date and time held, settable and queryable.
// - Line frequency only 50 or 60, stored.
// - Probe identity returns six fields in order.
// - Four independent identical status groups.
// - Condition register readable per group.
// - Positive transition mask, writable and readable.
// - Negative transition mask, writable and readable.
// - Event register holds latched transitions, readable.
// - Enable mask selects events for summary.
// - Preset restores filters and enables to defaults.
// - Clear status zeroes events, empties error queue.
package msc_pkg;

  localparam int MSC_NGRP = 4;
  localparam int MSC_SW = 16;
  localparam int MSC_DW = 32;

  // Status group indices.
  localparam logic [1:0] MSC_GRP_MEAS = 2'h0;
  localparam logic [1:0] MSC_GRP_AUX = 2'h1;
  localparam logic [1:0] MSC_GRP_OPER = 2'h2;
  localparam logic [1:0] MSC_GRP_QUES = 2'h3;

  // Defaults restored by reset and by the preset command.
  localparam logic [MSC_SW-1:0] MSC_PTR_DEFAULT = 16'hffff;
  localparam logic [MSC_SW-1:0] MSC_NTR_DEFAULT = 16'h0000;
  localparam logic [MSC_SW-1:0] MSC_ENA_DEFAULT = 16'h0000;

  // Standard level reported by the version query: major 1999, minor 0.
  localparam logic [15:0] MSC_VERSION_MAJOR = 16'h07cf;
  localparam logic [15:0] MSC_VERSION_MINOR = 16'h0000;

  // Allowed mains frequency values in hertz.
  localparam logic [7:0] MSC_LFREQ_50 = 8'h32;
  localparam logic [7:0] MSC_LFREQ_60 = 8'h3c;

  // Reset values of the system settings.
  localparam logic MSC_BEEP_RESET = 1'h1;
  localparam logic [15:0] MSC_YEAR_RESET = 16'h07d0;
  localparam logic [7:0] MSC_MONTH_RESET = 8'h01;
  localparam logic [7:0] MSC_DAY_RESET = 8'h01;
  localparam logic [23:0] MSC_TIME_RESET = 24'h000000;

  // Field positions in the date word and the time word.
  localparam int MSC_DATE_YEAR_LSB = 16;
  localparam int MSC_DATE_MONTH_LSB = 8;
  localparam int MSC_DATE_DAY_LSB = 0;
  localparam int MSC_TIME_HOUR_LSB = 16;
  localparam int MSC_TIME_MIN_LSB = 8;
  localparam int MSC_TIME_SEC_LSB = 0;

  // Number of fields of the probe identity answer, last index.
  localparam logic [2:0] MSC_PROBE_LAST = 3'h5;

  // Length of the beeper drive pulse in cycles.
  localparam int MSC_BEEP_CYCLES = 4;

  typedef enum logic [4:0] {
    MSC_CMD_TST,
    MSC_CMD_WAI,
    MSC_CMD_CLS,
    MSC_CMD_BEEP_IMM,
    MSC_CMD_BEEP_SET,
    MSC_CMD_BEEP_GET,
    MSC_CMD_VERSION,
    MSC_CMD_DATE_SET,
    MSC_CMD_DATE_GET,
    MSC_CMD_TIME_SET,
    MSC_CMD_TIME_GET,
    MSC_CMD_LFREQ_SET,
    MSC_CMD_LFREQ_GET,
    MSC_CMD_PROBE_ID,
    MSC_CMD_STAT_EVENT,
    MSC_CMD_STAT_COND,
    MSC_CMD_STAT_PTR_SET,
    MSC_CMD_STAT_PTR_GET,
    MSC_CMD_STAT_NTR_SET,
    MSC_CMD_STAT_NTR_GET,
    MSC_CMD_STAT_ENA_SET,
    MSC_CMD_STAT_ENA_GET,
    MSC_CMD_STAT_PRESET
  } msc_cmd_code_t;

  // A decoded command with its status group and its numeric argument.
  typedef struct packed {
    msc_cmd_code_t code;
    logic [1:0] grp;
    logic [MSC_DW-1:0] arg;
  } msc_cmd_t;

  // One answer word placed in the output queue; field counts words of a multi-word answer.
  typedef struct packed {
    logic [2:0] field;
    logic last;
    logic [MSC_DW-1:0] data;
  } msc_rsp_t;

  // Identity of the attached probe, as handles and integers.
  typedef struct packed {
    logic [MSC_DW-1:0] name;
    logic [MSC_DW-1:0] serial;
    logic [MSC_DW-1:0] cal_msg;
    logic [MSC_DW-1:0] ptype;
    logic [MSC_DW-1:0] subtype;
    logic [MSC_DW-1:0] flags;
  } msc_probe_t;

endpackage

// ===== verilog/msc_status_group.sv
// One status group: condition edge filters, latched events, enable mask and summary.
`timescale 1ns/1ps
module msc_status_group
  import msc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [MSC_SW-1:0] cond,
  input wire logic wr_ptr,
  input wire logic wr_ntr,
  input wire logic wr_ena,
  input wire logic [MSC_SW-1:0] wdata,
  input wire logic preset,
  input wire logic clear_evt,
  output logic [MSC_SW-1:0] ptr_reg,
  output logic [MSC_SW-1:0] ntr_reg,
  output logic [MSC_SW-1:0] ena_reg,
  output logic [MSC_SW-1:0] evt_reg,
  output logic summary
);

  logic [MSC_SW-1:0] cond_prev_reg;
  logic [MSC_SW-1:0] rise;
  logic [MSC_SW-1:0] fall;
  logic [MSC_SW-1:0] evt_set;
  logic [MSC_SW-1:0] evt_next;

  // Edges are seen against last cycle's condition, so a pulse shorter than a cycle is missed.
  assign rise = cond & ~cond_prev_reg;
  assign fall = ~cond & cond_prev_reg;
  assign evt_set = (rise & ptr_reg) | (fall & ntr_reg);
  // A new event beats a clear in the same cycle so that it is not lost.
  assign evt_next = (clear_evt ? '0 : evt_reg) | evt_set;
  assign summary = |(evt_reg & ena_reg);

  // Edge history and latched events.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cond_prev_reg <= '0;
      evt_reg <= '0;
    end
    else if (ce)
    begin
      cond_prev_reg <= cond;
      evt_reg <= evt_next;
    end
  end

  // Filter and enable masks; preset outranks a write in the same cycle.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ptr_reg <= MSC_PTR_DEFAULT;
      ntr_reg <= MSC_NTR_DEFAULT;
      ena_reg <= MSC_ENA_DEFAULT;
    end
    else if (ce)
    begin
      if (preset)
      begin
        ptr_reg <= MSC_PTR_DEFAULT;
        ntr_reg <= MSC_NTR_DEFAULT;
        ena_reg <= MSC_ENA_DEFAULT;
      end
      else
      begin
        if (wr_ptr)
          ptr_reg <= wdata;
        if (wr_ntr)
          ntr_reg <= wdata;
        if (wr_ena)
          ena_reg <= wdata;
      end
    end
  end

endmodule // msc_status_group

// ===== verilog/msc_top.sv
// Command executor for self-test, wait, system settings, probe identity and status groups.
`timescale 1ns/1ps
module msc_top
  import msc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic cmd_valid,
  input wire msc_cmd_t cmd,
  output logic cmd_ready,
  output logic rsp_valid,
  output msc_rsp_t rsp,
  output logic test_start,
  input wire logic test_done,
  input wire logic [7:0] test_fail_mask,
  input wire msc_probe_t probe,
  input wire logic [MSC_NGRP*MSC_SW-1:0] cond_in,
  output logic [MSC_NGRP-1:0] summary,
  output logic beep_enable,
  output logic beep_drive,
  output logic [7:0] mains_frequency_setting,
  output logic [MSC_DW-1:0] date_word,
  output logic [MSC_DW-1:0] time_word,
  output logic arg_error,
  output logic error_pending
);

  typedef enum logic [1:0] {
    MSC_ST_IDLE,
    MSC_ST_TEST,
    MSC_ST_PROBE
  } msc_state_t;

  // Registered state of the executor.
  msc_state_t state_reg;
  msc_state_t state_next;
  logic [2:0] probe_idx_reg;
  logic beep_en_reg;
  logic [2:0] beep_cnt_reg;
  logic [7:0] lfreq_reg;
  logic [MSC_DW-1:0] date_reg;
  logic [23:0] time_reg;
  logic err_reg;
  logic arg_err_reg;
  logic rsp_valid_reg;
  msc_rsp_t rsp_reg;
  logic test_start_reg;

  // Decoded command strobes and selections.
  logic take;
  logic [3:0] grp_sel;
  logic lfreq_ok;
  logic is_cls;
  logic rsp_imm;
  logic [MSC_DW-1:0] rsp_imm_data;
  logic [MSC_DW-1:0] probe_field;
  logic [MSC_SW-1:0] wdata;
  // Per-group register views, indexed by group number.
  logic [MSC_SW-1:0] ptr_q [MSC_NGRP];
  logic [MSC_SW-1:0] ntr_q [MSC_NGRP];
  logic [MSC_SW-1:0] ena_q [MSC_NGRP];
  logic [MSC_SW-1:0] evt_q [MSC_NGRP];
  logic [MSC_SW-1:0] cond_q [MSC_NGRP];
  logic lf_is_50;
  logic lf_is_60;
  logic do_tst;
  logic do_probe;
  logic do_beep_imm;
  logic do_preset;
  logic bad_lfreq;
  logic [MSC_NGRP-1:0] do_ptr_set;
  logic [MSC_NGRP-1:0] do_ntr_set;
  logic [MSC_NGRP-1:0] do_ena_set;
  logic [MSC_NGRP-1:0] do_evt_clr;

  // Commands are only taken while idle; multi-cycle queries hold the port off.
  assign cmd_ready = (state_reg == MSC_ST_IDLE);
  assign take = cmd_valid && cmd_ready && ce;
  assign grp_sel = 4'h1 << cmd.grp;
  assign wdata = cmd.arg[MSC_SW-1:0];
  assign is_cls = take && (cmd.code == MSC_CMD_CLS);
  // The whole argument is compared, so a value with stray high bits is refused.
  assign lf_is_50 = (cmd.arg == {24'h000000, MSC_LFREQ_50});
  assign lf_is_60 = (cmd.arg == {24'h000000, MSC_LFREQ_60});
  assign lfreq_ok = lf_is_50 || lf_is_60;

  // One strobe per taken command, each true for the single take cycle.
  assign do_tst = take && (cmd.code == MSC_CMD_TST);
  assign do_probe = take && (cmd.code == MSC_CMD_PROBE_ID);
  assign do_beep_imm = take && (cmd.code == MSC_CMD_BEEP_IMM);
  assign do_preset = take && (cmd.code == MSC_CMD_STAT_PRESET);
  assign bad_lfreq = take && (cmd.code == MSC_CMD_LFREQ_SET) && !lfreq_ok;
  // Mask writes land only in the addressed group.
  assign do_ptr_set = (take && cmd.code == MSC_CMD_STAT_PTR_SET) ? grp_sel : '0;
  assign do_ntr_set = (take && cmd.code == MSC_CMD_STAT_NTR_SET) ? grp_sel : '0;
  assign do_ena_set = (take && cmd.code == MSC_CMD_STAT_ENA_SET) ? grp_sel : '0;
  // Clear-status wipes every group, an event read only the addressed one.
  assign do_evt_clr = {MSC_NGRP{is_cls}} |
                      ((take && cmd.code == MSC_CMD_STAT_EVENT) ? grp_sel : '0);

  // Four identical groups; event reads and clear-status both wipe events.
  genvar g;
  generate
    for (g = 0; g < MSC_NGRP; g = g + 1)
    begin : gen_grp
      assign cond_q[g] = cond_in[g*MSC_SW +: MSC_SW];
      msc_status_group u_grp (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .ce(ce),
        .cond(cond_q[g]),
        .wr_ptr(do_ptr_set[g]),
        .wr_ntr(do_ntr_set[g]),
        .wr_ena(do_ena_set[g]),
        .wdata(wdata),
        .preset(do_preset),
        .clear_evt(do_evt_clr[g]),
        .ptr_reg(ptr_q[g]),
        .ntr_reg(ntr_q[g]),
        .ena_reg(ena_q[g]),
        .evt_reg(evt_q[g]),
        .summary(summary[g])
      );
    end
  endgenerate

  // Single-word answers, selected from the present register values.
  always_comb
  begin
    rsp_imm = 1'b1;
    rsp_imm_data = '0;
    case (cmd.code)
      MSC_CMD_BEEP_GET: rsp_imm_data = {31'h00000000, beep_en_reg};
      MSC_CMD_VERSION: rsp_imm_data = {MSC_VERSION_MAJOR, MSC_VERSION_MINOR};
      MSC_CMD_DATE_GET: rsp_imm_data = date_reg;
      MSC_CMD_TIME_GET: rsp_imm_data = {8'h00, time_reg};
      MSC_CMD_LFREQ_GET: rsp_imm_data = {24'h000000, lfreq_reg};
      MSC_CMD_STAT_EVENT: rsp_imm_data = {16'h0000, evt_q[cmd.grp]};
      MSC_CMD_STAT_COND: rsp_imm_data = {16'h0000, cond_q[cmd.grp]};
      MSC_CMD_STAT_PTR_GET: rsp_imm_data = {16'h0000, ptr_q[cmd.grp]};
      MSC_CMD_STAT_NTR_GET: rsp_imm_data = {16'h0000, ntr_q[cmd.grp]};
      MSC_CMD_STAT_ENA_GET: rsp_imm_data = {16'h0000, ena_q[cmd.grp]};
      default: rsp_imm = 1'b0;
    endcase
  end

  // Probe identity words in their fixed order.
  always_comb
  begin
    case (probe_idx_reg)
      3'h0: probe_field = probe.name;
      3'h1: probe_field = probe.serial;
      3'h2: probe_field = probe.cal_msg;
      3'h3: probe_field = probe.ptype;
      3'h4: probe_field = probe.subtype;
      default: probe_field = probe.flags;
    endcase
  end

  // Sequencer for the self-test and the multi-word identity answer.
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      MSC_ST_IDLE:
      begin
        if (do_tst)
          state_next = MSC_ST_TEST;
        else if (do_probe)
          state_next = MSC_ST_PROBE;
      end
      MSC_ST_TEST:
      begin
        if (test_done)
          state_next = MSC_ST_IDLE;
      end
      MSC_ST_PROBE:
      begin
        if (probe_idx_reg == MSC_PROBE_LAST)
          state_next = MSC_ST_IDLE;
      end
      default: state_next = MSC_ST_IDLE;
    endcase
  end

  // State, probe word counter and self-test launch pulse.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= MSC_ST_IDLE;
      probe_idx_reg <= 3'h0;
      test_start_reg <= 1'b0;
    end
    else if (ce)
    begin
      state_reg <= state_next;
      probe_idx_reg <= (state_reg == MSC_ST_PROBE) ? probe_idx_reg + 3'h1 : 3'h0;
      test_start_reg <= do_tst;
    end
  end

  // Answer register: one word per cycle that rsp_valid is high, held until the next answer.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rsp_valid_reg <= 1'b0;
      rsp_reg <= '0;
    end
    else if (ce)
    begin
      rsp_valid_reg <= 1'b0;
      if (state_reg == MSC_ST_TEST && test_done)
      begin
        rsp_valid_reg <= 1'b1;
        // The code is the mask of failed tests, so all passing gives zero.
        rsp_reg <= '{field: 3'h0, last: 1'b1, data: {24'h000000, test_fail_mask}};
      end
      else if (state_reg == MSC_ST_PROBE)
      begin
        // Each identity word goes out on its own cycle, numbered from zero.
        rsp_valid_reg <= 1'b1;
        rsp_reg <= '{field: probe_idx_reg, last: probe_idx_reg == MSC_PROBE_LAST,
                     data: probe_field};
      end
      else if (take && rsp_imm)
      begin
        rsp_valid_reg <= 1'b1;
        rsp_reg <= '{field: 3'h0, last: 1'b1, data: rsp_imm_data};
      end
    end
  end

  // System settings; the wait command falls through and touches nothing.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      beep_en_reg <= MSC_BEEP_RESET;
      lfreq_reg <= MSC_LFREQ_50;
      date_reg <= {MSC_YEAR_RESET, MSC_MONTH_RESET, MSC_DAY_RESET};
      time_reg <= MSC_TIME_RESET;
    end
    else if (take)
    begin
      if (cmd.code == MSC_CMD_BEEP_SET)
        beep_en_reg <= cmd.arg[0];
      if (cmd.code == MSC_CMD_DATE_SET)
        date_reg <= cmd.arg;
      if (cmd.code == MSC_CMD_TIME_SET)
        time_reg <= cmd.arg[23:0];
      if (cmd.code == MSC_CMD_LFREQ_SET && lfreq_ok)
        lfreq_reg <= cmd.arg[7:0];
    end
  end

  // Beeper pulse: a fixed-length drive so a short tone is audible; not started when disabled, a running pulse runs out.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      beep_cnt_reg <= 3'h0;
    else if (ce)
    begin
      if (do_beep_imm && beep_en_reg)
        beep_cnt_reg <= 3'(MSC_BEEP_CYCLES);
      else if (beep_cnt_reg != 3'h0)
        beep_cnt_reg <= beep_cnt_reg - 3'h1;
    end
  end

  // Error queue stand-in: a bad mains value sets it, clear-status empties it, set wins.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      err_reg <= 1'b0;
      arg_err_reg <= 1'b0;
    end
    else if (ce)
    begin
      arg_err_reg <= bad_lfreq;
      if (bad_lfreq)
        err_reg <= 1'b1;
      else if (is_cls)
        err_reg <= 1'b0;
    end
  end

  // The wait command is taken like any other and has no decode of its own.
  assign rsp_valid = rsp_valid_reg;
  assign rsp = rsp_reg;
  assign test_start = test_start_reg;
  assign beep_enable = beep_en_reg;
  assign beep_drive = (beep_cnt_reg != 3'h0);
  assign mains_frequency_setting = lfreq_reg;
  assign date_word = date_reg;
  assign time_word = {8'h00, time_reg};
  assign arg_error = arg_err_reg;
  assign error_pending = err_reg;

endmodule // msc_top

// ===== testbench/msc_checker.sv
// Concurrent port checks for the meter status and system command block.
`timescale 1ns/1ps
module msc_checker
  import msc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic cmd_valid,
  input wire msc_cmd_t cmd,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire msc_rsp_t rsp,
  input wire logic test_start,
  input wire logic test_done,
  input wire logic [7:0] test_fail_mask,
  input wire logic [MSC_NGRP-1:0] summary,
  input wire logic beep_enable,
  input wire logic beep_drive,
  input wire logic [7:0] mains_frequency_setting,
  input wire logic arg_error,
  input wire logic error_pending
);
  logic take;
  logic lf_ok;
  // A command counts only on an edge where it is offered, accepted and enabled.
  assign take = cmd_valid && cmd_ready && ce;
  // The whole argument must name one of the two values.
  assign lf_ok = (cmd.arg == {24'h000000, MSC_LFREQ_50}) ||
                 (cmd.arg == {24'h000000, MSC_LFREQ_60});
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_test_launch:
    assert property (take && cmd.code == MSC_CMD_TST |=> test_start && !cmd_ready ##1 !test_start)
    else $error("self-test start pulse wrong");
  a_test_result:
    assert property (ce && test_done && !cmd_ready |=>
      rsp_valid && rsp.data == {24'h000000, $past(test_fail_mask)})
    else $error("self-test result code wrong");
  a_wait_silent:
    assert property (take && cmd.code == MSC_CMD_WAI |=> !rsp_valid && !arg_error)
    else $error("wait command produced output");
  a_beep_length:
    assert property ($rose(beep_drive) |-> beep_drive [*4] ##1 !beep_drive)
    else $error("beeper pulse length wrong");
  a_beep_quiet:
    assert property (take && cmd.code == MSC_CMD_BEEP_IMM && !beep_enable |=> !beep_drive [*6])
    else $error("disabled beeper sounded");
  a_version_answer:
    assert property (take && cmd.code == MSC_CMD_VERSION |=> rsp_valid && rsp.data == 32'h07cf0000)
    else $error("version answer wrong");
  a_mains_store:
    assert property (take && cmd.code == MSC_CMD_LFREQ_SET && lf_ok |=>
      !arg_error && mains_frequency_setting == $past(cmd.arg[7:0]))
    else $error("mains frequency not stored");
  a_mains_refuse:
    assert property (take && cmd.code == MSC_CMD_LFREQ_SET && !lf_ok |=>
      arg_error && error_pending && $stable(mains_frequency_setting))
    else $error("bad mains frequency accepted");
  a_probe_burst:
    assert property (take && cmd.code == MSC_CMD_PROBE_ID |=> ##1 rsp_valid && rsp.field == 3'h0
      && !rsp.last ##5 rsp_valid && rsp.last && rsp.field == MSC_PROBE_LAST)
    else $error("probe identity burst wrong");
  a_event_upper:
    assert property (take && cmd.code == MSC_CMD_STAT_EVENT |=> rsp_valid && rsp.data[31:16] == 16'h0000)
    else $error("event answer wrong");
  a_preset_quiet:
    assert property (take && cmd.code == MSC_CMD_STAT_PRESET |=> summary == 4'h0)
    else $error("summary set after preset");
  a_clear_error:
    assert property (take && cmd.code == MSC_CMD_CLS |=> !error_pending)
    else $error("error not cleared");
endmodule // msc_checker

bind msc_top msc_checker i_chk (.*);

// ===== testbench/msc_test_model.sv
// Behavioural self-test engine that answers the block's start pulse.
`timescale 1ns/1ps
module msc_test_model
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic test_start,
  input wire logic [7:0] fail_code,
  output logic test_done,
  output logic [7:0] test_fail_mask
);
  logic [3:0] wait_reg;
  // Outside done the inverse is shown, so a stale sample of the mask is caught.
  assign test_fail_mask = test_done ? fail_code : ~fail_code;
  assign test_done = (wait_reg == 4'h1);
  // The test takes a few cycles, so the answer is never next to the start.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      wait_reg <= 4'h0;
    else if (test_start)
      wait_reg <= 4'h3;
    else if (wait_reg != 4'h0)
      wait_reg <= wait_reg - 4'h1;
  end
endmodule // msc_test_model

// ===== testbench/tb_top.sv
// Directed bench for the meter status and system command block.
`timescale 1ns/1ps
module tb_top
  import msc_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic cmd_valid = 1'b0;
  msc_cmd_t cmd = '0;
  msc_probe_t probe = '0;
  logic [63:0] cond_in = 64'h0;
  logic [7:0] fail_code = 8'h00;
  logic cmd_ready, rsp_valid, test_start, test_done, beep_enable, beep_drive, arg_error;
  logic error_pending, rv, ae;
  msc_rsp_t rsp;
  logic [7:0] test_fail_mask, mains_frequency_setting;
  logic [3:0] summary;
  logic [31:0] date_word, time_word, rd;
  int n_errors = 0;
  int checks = 0;
  int beeps = 0;

  msc_top i_dut (.*);
  msc_test_model i_eng (.*);

  // Free-running core clock; the beeper is counted apart from command timing.
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk)
    if (beep_drive === 1'b1)
      beeps++;

  task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // Waits for ready, offers one command, keeps the first answer cycle, then idles a cycle.
  task automatic send(msc_cmd_code_t c, int g, logic [31:0] a);
    int k;
    k = 0;
    while (cmd_ready !== 1'b1 && k < 50)
    begin
      tick(1);
      k++;
    end
    cmp("ready_wait", 32'h1, 32'(cmd_ready));
    cmd = '{code: c, grp: 2'(g), arg: a};
    cmd_valid = 1'b1;
    tick(1);
    rv = rsp_valid;
    rd = rsp.data;
    ae = arg_error;
    cmd_valid = 1'b0;
    tick(1);
  endtask

  task automatic ask(msc_cmd_code_t c, int g, logic [31:0] e, string nm);
    send(c, g, 32'h0);
    cmp(nm, {e[31:1], 1'b1}, {rd[31:1], rv});
    cmp(nm, e, rd);
  endtask

  task automatic t_reset();
    cmp("ready", 32'h1, 32'(cmd_ready));
    cmp("beep_en", 32'h1, 32'(beep_enable));
    cmp("mains", 32'h32, 32'(mains_frequency_setting));
    cmp("date", 32'h07d00101, date_word);
    cmp("time", 32'h0, time_word);
  endtask

  task automatic t_self(logic [7:0] code);
    int k;
    fail_code = code;
    send(MSC_CMD_TST, 0, 32'h0);
    k = 0;
    while (rsp_valid !== 1'b1 && k < 20)
    begin
      tick(1);
      k++;
    end
    cmp("selftest_rv", 32'h1, 32'(rsp_valid));
    cmp("selftest", {24'h0, code}, rsp.data);
  endtask

  task automatic t_sys();
    send(MSC_CMD_WAI, 0, 32'h0);
    cmp("wai", 32'h0, 32'(rv));
    ask(MSC_CMD_VERSION, 0, 32'h07cf0000, "version");
    send(MSC_CMD_DATE_SET, 0, 32'h07e80c1f);
    ask(MSC_CMD_DATE_GET, 0, 32'h07e80c1f, "date_q");
    // With the clock enable low an offered command must leave the calendar alone.
    ce = 1'b0;
    send(MSC_CMD_DATE_SET, 0, 32'h11111111);
    ce = 1'b1;
    cmp("date_ce", 32'h07e80c1f, date_word);
    send(MSC_CMD_TIME_SET, 0, 32'h00173b3a);
    ask(MSC_CMD_TIME_GET, 0, 32'h00173b3a, "time_q");
    cmp("time", 32'h00173b3a, time_word);
  endtask

  task automatic t_beep();
    send(MSC_CMD_BEEP_SET, 0, 32'h0);
    cmp("beep_en", 32'h0, 32'(beep_enable));
    ask(MSC_CMD_BEEP_GET, 0, 32'h0, "beep_q");
    beeps = 0;
    send(MSC_CMD_BEEP_IMM, 0, 32'h0);
    tick(8);
    cmp("beeps_off", 32'h0, 32'(beeps));
    send(MSC_CMD_BEEP_SET, 0, 32'h1);
    ask(MSC_CMD_BEEP_GET, 0, 32'h1, "beep_q");
    send(MSC_CMD_BEEP_IMM, 0, 32'h0);
    tick(8);
    cmp("beeps_on", 32'h4, 32'(beeps));
  endtask

  // A value off the two allowed ones must leave the last good setting in place.
  task automatic t_mains();
    logic [7:0] v[3] = '{8'h3c, 8'h3d, 8'h32};
    logic [7:0] e[3] = '{8'h3c, 8'h3c, 8'h32};
    for (int i = 0; i < 3; i++)
    begin
      send(MSC_CMD_LFREQ_SET, 0, {24'h0, v[i]});
      cmp("arg_err", 32'(i == 1), 32'(ae));
      ask(MSC_CMD_LFREQ_GET, 0, {24'h0, e[i]}, "mains_q");
    end
    cmp("err_pend", 32'h1, 32'(error_pending));
  endtask

  task automatic t_probe();
    for (int k = 0; k < 6; k++)
      probe[(5 - k) * 32 +: 32] = 32'h5a000000 | k;
    send(MSC_CMD_PROBE_ID, 0, 32'h0);
    // The first word is launched one edge after the take, so nothing stands yet.
    cmp("probe_rv0", 32'h0, 32'(rv));
    for (int k = 0; k < 6; k++)
    begin
      logic [31:0] ef;
      ef = 32'h10 + 32'(k) + ((k == 5) ? 32'h8 : 32'h0);
      cmp("field", ef, {27'h0, rsp_valid, rsp.last, rsp.field});
      cmp("probe", 32'h5a000000 | k, rsp.data);
      tick(1);
    end
  endtask

  // Bit 0 latches on its rise only, bit 1 on its fall only.
  task automatic t_group(int g);
    send(MSC_CMD_STAT_PTR_SET, g, 32'h1);
    send(MSC_CMD_STAT_NTR_SET, g, 32'h2);
    send(MSC_CMD_STAT_ENA_SET, g, 32'h1);
    ask(MSC_CMD_STAT_PTR_GET, g, 32'h1, "ptr");
    ask(MSC_CMD_STAT_NTR_GET, g, 32'h2, "ntr");
    ask(MSC_CMD_STAT_ENA_GET, g, 32'h1, "ena");
    cond_in[16 * g +: 16] = 16'h0003;
    tick(3);
    ask(MSC_CMD_STAT_COND, g, 32'h3, "cond");
    cmp("summary", 32'(1 << g), 32'(summary));
    cond_in[16 * g +: 16] = 16'h0000;
    tick(3);
    ask(MSC_CMD_STAT_EVENT, g, 32'h3, "event");
    cmp("summary0", 32'h0, 32'(summary));
    ask(MSC_CMD_STAT_EVENT, g, 32'h0, "event_rd");
  endtask

  task automatic t_preset();
    send(MSC_CMD_STAT_PRESET, 0, 32'h0);
    for (int g = 0; g < 4; g++)
    begin
      ask(MSC_CMD_STAT_PTR_GET, g, 32'hffff, "ptr_p");
      ask(MSC_CMD_STAT_NTR_GET, g, 32'h0, "ntr_p");
      ask(MSC_CMD_STAT_ENA_GET, g, 32'h0, "ena_p");
    end
    cond_in[15:0] = 16'h0010;
    tick(3);
    send(MSC_CMD_CLS, 0, 32'h0);
    ask(MSC_CMD_STAT_EVENT, 0, 32'h0, "event_cls");
    cmp("err_cls", 32'h0, 32'(error_pending));
  endtask

  task automatic close_out();
    if (n_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Main sequence after ten cycles of reset.
  initial
  begin
    tick(10);
    rst_n = 1'b1;
    tick(1);
    t_reset();
    t_self(8'h00);
    t_self(8'h05);
    t_sys();
    t_beep();
    t_mains();
    t_probe();
    for (int g = 0; g < 4; g++)
      t_group(g);
    t_preset();
    close_out();
  end

  // The tests need about two hundred cycles; this limit only cuts a hang.
  initial
  begin
    #100000;
    n_errors++;
    close_out();
  end
endmodule // tb_top
